// File: common/irq_pkg.sv
// Shared constants and types of the device interrupt enable logic
package irq_pkg;
    localparam int unsigned      REG_W          = 16;
    localparam int unsigned      DATA_W         = 32;
    localparam int unsigned      ADDR_W         = 12;
    localparam logic [11:0]      OFF_ENABLE_CLR = 12'h014;
    localparam logic [11:0]      OFF_ENABLE_SET = 12'h018;
    localparam logic [11:0]      OFF_FLAG       = 12'h01C;
    localparam logic [11:0]      OFF_EVT_STATUS = 12'h024;
    localparam logic [11:0]      OFF_EVT_CLEAR  = 12'h028;
    localparam logic [11:0]      OFF_EVT_ENABLE = 12'h02C;
    localparam int unsigned      BIT_SUSPEND    = 0;
    localparam int unsigned      BIT_SOF        = 2;
    localparam int unsigned      BIT_BUS_RESET  = 3;
    localparam int unsigned      BIT_LINE_ACT   = 4;
    localparam int unsigned      BIT_END_RESUME = 5;
    localparam int unsigned      BIT_UP_RESUME  = 6;
    localparam int unsigned      BIT_RAM_UFLOW  = 7;
    localparam int unsigned      BIT_LPM_NYET   = 8;
    localparam int unsigned      BIT_LPM_SUSP   = 9;
    localparam logic [15:0]      EVT_MASK       = 16'h03FD;
    localparam logic [15:0]      ENABLE_RST     = 16'h0000;
    localparam logic [15:0]      FLAG_RST       = 16'h0000;
    localparam int unsigned      CLK_MHZ        = 250;
    localparam int unsigned      FRAME_US       = 1000;
    localparam int unsigned      SUSPEND_MS     = 3;
    localparam int unsigned      SUSPEND_FRAMES = SUSPEND_MS * 1000 / FRAME_US;
    localparam int unsigned      FRAME_CYC      = FRAME_US * CLK_MHZ;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACCESS = 2'b01,
        ST_DONE   = 2'b10
    } apb_state_t;
endpackage : irq_pkg

// File: rtl/suspend_timer.sv
// Idle-time counter that reports bus suspend after three idle frames
`timescale 1ns/10ps
module suspend_timer
    import irq_pkg::*;
#(
    parameter int unsigned IDLE_CYC = SUSPEND_FRAMES * FRAME_CYC
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic line_idle,
    output logic      suspend_pulse
);
    logic [31:0] idle_cnt_r;
    logic        fired_r;

    // Pulse once per idle period; line activity restarts the count
    always_ff @(posedge clk) begin
        if (sys_rst || !line_idle) begin
            idle_cnt_r    <= 32'h0000_0000;
            fired_r       <= 1'b0;
            suspend_pulse <= 1'b0;
        end else if (!fired_r && idle_cnt_r == IDLE_CYC - 1) begin
            fired_r       <= 1'b1;
            suspend_pulse <= 1'b1;
        end else begin
            suspend_pulse <= 1'b0;
            if (!fired_r) begin
                idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
            end
        end
    end
endmodule : suspend_timer

// File: rtl/usb_device_irq_enable_logic.sv
// Shared interrupt enables, event flags and APB slave of the USB device
`timescale 1ns/10ps
module usb_device_irq_enable_logic (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire irq_pkg::apb_req_t apb_req,
    output irq_pkg::apb_rsp_t      apb_rsp,
    input  wire logic [15:0]       event_pulse,
    input  wire logic              line_idle,
    output logic                   irq
);
    import irq_pkg::*;

    logic [15:0] enable_r;
    logic [15:0] flag_r;
    logic [15:0] evt_status_r;
    logic [15:0] evt_enable_r;
    logic [1:0]  idle_sync_r;
    logic        suspend_pulse;
    logic [15:0] set_in;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit;
    logic [15:0] wdata;
    logic [15:0] rdata;
    apb_state_t  state_r;

    // Line idle comes from the line clock domain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idle_sync_r <= 2'b00;
        end else begin
            idle_sync_r <= {idle_sync_r[0], line_idle};
        end
    end

    suspend_timer u_suspend_timer (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .line_idle     (idle_sync_r[1]),
        .suspend_pulse (suspend_pulse)
    );

    // Suspend comes from the local timer; the rest from the detectors
    always_comb begin
        set_in              = event_pulse & EVT_MASK;
        set_in[BIT_SUSPEND] = suspend_pulse;
    end

    assign wdata  = apb_req.pwdata[15:0];
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && state_r == ST_ACCESS;
    assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite && state_r == ST_ACCESS;

    // Slave answers one cycle into the access phase
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (apb_req.psel && !apb_req.penable) begin
                        state_r <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    state_r <= ST_DONE;
                end
                ST_DONE: begin
                    state_r <= (apb_req.psel && !apb_req.penable) ? ST_ACCESS : ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // One shared enable behind both addresses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_r <= ENABLE_RST;
        end else if (wr_acc && apb_req.paddr == OFF_ENABLE_SET) begin
            enable_r <= enable_r | (wdata & EVT_MASK);
        end else if (wr_acc && apb_req.paddr == OFF_ENABLE_CLR) begin
            enable_r <= enable_r & ~(wdata & EVT_MASK);
        end
    end

    // Set wins over a simultaneous clear so no event is lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_r <= FLAG_RST;
        end else if (wr_acc && apb_req.paddr == OFF_FLAG) begin
            flag_r <= (flag_r & ~wdata & EVT_MASK) | set_in;
        end else begin
            flag_r <= flag_r | set_in;
        end
    end

    // Sticky record of events with its own clear and enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evt_status_r <= FLAG_RST;
        end else if (wr_acc && apb_req.paddr == OFF_EVT_CLEAR) begin
            evt_status_r <= (evt_status_r & ~wdata) | set_in;
        end else begin
            evt_status_r <= evt_status_r | set_in;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evt_enable_r <= ENABLE_RST;
        end else if (wr_acc && apb_req.paddr == OFF_EVT_ENABLE) begin
            evt_enable_r <= wdata & EVT_MASK;
        end
    end

    // Registered so the output is glitch free; one cycle behind the flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_r & enable_r) || |(evt_status_r & evt_enable_r);
        end
    end

    always_comb begin
        hit   = 1'b1;
        rdata = 16'h0000;
        case (apb_req.paddr)
            OFF_ENABLE_CLR: rdata = enable_r;
            OFF_ENABLE_SET: rdata = enable_r;
            OFF_FLAG:       rdata = flag_r;
            OFF_EVT_STATUS: rdata = evt_status_r;
            OFF_EVT_CLEAR:  rdata = 16'h0000;
            OFF_EVT_ENABLE: rdata = evt_enable_r;
            default:        hit   = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp.pready  <= apb_req.psel && apb_req.penable && state_r == ST_ACCESS;
            apb_rsp.pslverr <= apb_req.psel && apb_req.penable && state_r == ST_ACCESS && !hit;
            apb_rsp.prdata  <= rd_acc ? {16'h0000, rdata} : 32'h0000_0000;
        end
    end

    // Assertions
    property p_clr_en;
        @(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_ENABLE_CLR |=> (enable_r & $past(wdata) & EVT_MASK) == 0;
    endproperty
    a_clr_en: assert property (p_clr_en) else $error("enable not cleared");

    property p_clr_zero;
        @(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_ENABLE_CLR && wdata == 0 |=> $stable(enable_r);
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("zero clear changed enables");

    // Bits written as zero must survive either side
    property p_clr_others;
        @(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_ENABLE_CLR
        |=> (enable_r & ~$past(wdata)) == ($past(enable_r) & ~$past(wdata));
    endproperty
    a_clr_others: assert property (p_clr_others) else $error("clear hit other bits");

    property p_set_others;
        @(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_ENABLE_SET
        |=> (enable_r & ~$past(wdata)) == ($past(enable_r) & ~$past(wdata));
    endproperty
    a_set_others: assert property (p_set_others) else $error("set hit other bits");

    property p_en_reserved;
        @(posedge clk) disable iff (sys_rst)
        (enable_r & ~EVT_MASK) == 16'h0000;
    endproperty
    a_en_reserved: assert property (p_en_reserved) else $error("reserved enable set");

    property p_flag_reserved;
        @(posedge clk) disable iff (sys_rst)
        (flag_r & ~EVT_MASK) == 16'h0000;
    endproperty
    a_flag_reserved: assert property (p_flag_reserved) else $error("reserved flag set");

    // Both addresses must return the one shared state
    property p_rd_shared;
        @(posedge clk) disable iff (sys_rst)
        rd_acc && (apb_req.paddr == OFF_ENABLE_CLR || apb_req.paddr == OFF_ENABLE_SET)
        |=> apb_rsp.prdata == {16'h0000, $past(enable_r)};
    endproperty
    a_rd_shared: assert property (p_rd_shared) else $error("enable readback wrong");

    property p_rd_flag;
        @(posedge clk) disable iff (sys_rst)
        rd_acc && apb_req.paddr == OFF_FLAG |=> apb_rsp.prdata == {16'h0000, $past(flag_r)};
    endproperty
    a_rd_flag: assert property (p_rd_flag) else $error("flag readback wrong");

    property p_flag_hold;
        @(posedge clk) disable iff (sys_rst)
        !(wr_acc && apb_req.paddr == OFF_FLAG) && set_in == 16'h0000 |=> $stable(flag_r);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag moved by itself");

    property p_flag_zero;
        @(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_FLAG && wdata == 0 && set_in == 16'h0000
        |=> $stable(flag_r);
    endproperty
    a_flag_zero: assert property (p_flag_zero) else $error("zero write cleared flag");

    property p_irq_low;
        @(posedge clk) disable iff (sys_rst)
        (flag_r & enable_r) == 16'h0000 && (evt_status_r & evt_enable_r) == 16'h0000 |=> !irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("request while disabled");

    property p_irq_high;
        @(posedge clk) disable iff (sys_rst)
        (flag_r & enable_r) != 16'h0000 |=> irq;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("enabled flag without request");

    // Reset values seen at the first edge after release
    property p_rst_vals;
        @(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> flag_r == FLAG_RST && enable_r == ENABLE_RST;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset value");

    // Bus answer stands exactly one cycle
    property p_pready_pulse;
        @(posedge clk) disable iff (sys_rst)
        apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");

    property p_slverr;
        @(posedge clk) disable iff (sys_rst)
        apb_rsp.pslverr |-> apb_rsp.pready;
    endproperty
    a_slverr: assert property (p_slverr) else $error("error without ready");

    property p_upper_zero;
        @(posedge clk) disable iff (sys_rst)
        apb_rsp.prdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");

    // One register update per transfer
    property p_one_write;
        @(posedge clk) disable iff (sys_rst)
        wr_acc |=> !wr_acc;
    endproperty
    a_one_write: assert property (p_one_write) else $error("double write");

    property p_state_legal;
        @(posedge clk) disable iff (sys_rst)
        state_r inside {ST_IDLE, ST_ACCESS, ST_DONE};
    endproperty
    a_state_legal: assert property (p_state_legal) else $error("illegal bus state");

    property p_zero_keep;
        @(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_ENABLE_SET && wdata == 0 |=> $stable(enable_r);
    endproperty
    a_zero_keep: assert property (p_zero_keep) else $error("zero write changed enables");
    property p_set_en;
        @(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_ENABLE_SET |=> (($past(wdata) & EVT_MASK) & ~enable_r) == 0;
    endproperty
    a_set_en: assert property (p_set_en) else $error("enable not set");
    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        ##1 irq == $past(|(flag_r & enable_r) || |(evt_status_r & evt_enable_r));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_bit1;
        @(posedge clk) disable iff (sys_rst) !enable_r[1] && !flag_r[1];
    endproperty
    a_bit1: assert property (p_bit1) else $error("unused bit set");
    property p_flag_clr;
        @(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_FLAG && wdata[BIT_SOF] && !set_in[BIT_SOF]
        |=> !flag_r[BIT_SOF];
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
    property p_sof;
        @(posedge clk) disable iff (sys_rst) set_in[BIT_SOF] |=> flag_r[BIT_SOF];
    endproperty
    a_sof: assert property (p_sof) else $error("sof flag lost");
    property p_req;
        @(posedge clk) disable iff (sys_rst)
        flag_r[BIT_SUSPEND] && enable_r[BIT_SUSPEND] |=> irq;
    endproperty
    a_req: assert property (p_req) else $error("missing request");
    property p_susp;
        @(posedge clk) disable iff (sys_rst) suspend_pulse |=> flag_r[BIT_SUSPEND];
    endproperty
    a_susp: assert property (p_susp) else $error("suspend flag lost");
    c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
    c_clr: cover property (@(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_ENABLE_CLR);
    c_susp: cover property (@(posedge clk) disable iff (sys_rst) suspend_pulse);
    c_flag_clr: cover property (@(posedge clk) disable iff (sys_rst)
        wr_acc && apb_req.paddr == OFF_FLAG && wdata != 16'h0000);
    c_sof_irq: cover property (@(posedge clk) disable iff (sys_rst)
        flag_r[BIT_SOF] && enable_r[BIT_SOF] ##1 irq);
endmodule : usb_device_irq_enable_logic

// File: tb/usb_device_irq_enable_logic_bench.sv
// Self-checking bench for the device interrupt enable logic
`timescale 1ns/10ps
module usb_device_irq_enable_logic_bench;
    import irq_pkg::*;
    logic        clk;
    logic        sys_rst;
    apb_req_t    req;
    apb_rsp_t    rsp;
    logic [15:0] ev;
    logic        line_idle;
    logic        irq;
    int          mismatches;
    int          checks;
    logic [31:0] rd;
    logic        err;

    usb_device_irq_enable_logic u_dut (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .apb_req     (req),
        .apb_rsp     (rsp),
        .event_pulse (ev),
        .line_idle   (line_idle),
        .irq         (irq)
    );

    always #2 clk = ~clk;

    task automatic finish_test();
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Holds the request until pready is sampled; an edge passes before the next setup
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        req.paddr   <= a;
        req.pwrite  <= w;
        req.pwdata  <= d;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        chk("pready", 32'h0000_0001, 32'(rsp.pready));
        rd  = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rdchk

    task automatic pulse(input int b);
        ev <= 16'h0001 << b;
        @(posedge clk);
        ev <= 16'h0000;
        tick(3);
    endtask : pulse

    task automatic t_reset();
        rdchk("enable_set", OFF_ENABLE_SET, 32'h0000_0000);
        rdchk("enable_clr", OFF_ENABLE_CLR, 32'h0000_0000);
        rdchk("flags", OFF_FLAG, 32'h0000_0000);
        chk("irq", 32'h0000_0000, 32'(irq));
    endtask : t_reset

    task automatic t_enables();
        // Reserved bit 1 and 15:10 must not stick
        apb(1'b1, OFF_ENABLE_SET, 32'hFFFF_FFFF);
        rdchk("enable_set", OFF_ENABLE_SET, 32'h0000_03FD);
        rdchk("enable_clr", OFF_ENABLE_CLR, 32'h0000_03FD);
        apb(1'b1, OFF_ENABLE_CLR, 32'h0000_0204);
        rdchk("enable_set", OFF_ENABLE_SET, 32'h0000_01F9);
        apb(1'b1, OFF_ENABLE_SET, 32'h0000_0000);
        apb(1'b1, OFF_ENABLE_CLR, 32'h0000_0000);
        rdchk("enable_clr", OFF_ENABLE_CLR, 32'h0000_01F9);
        apb(1'b1, OFF_ENABLE_SET, 32'h0000_0204);
        rdchk("enable_set", OFF_ENABLE_SET, 32'h0000_03FD);
    endtask : t_enables

    task automatic t_flags();
        for (int b = BIT_SOF; b <= BIT_LPM_SUSP; b++) begin
            pulse(b);
            chk("irq", 32'h0000_0001, 32'(irq));
            rdchk("flags", OFF_FLAG, 32'h0000_0001 << b);
            apb(1'b1, OFF_FLAG, 32'h0000_0000);
            rdchk("flags", OFF_FLAG, 32'h0000_0001 << b);
            apb(1'b1, OFF_FLAG, 32'h0000_0001 << b);
            tick(1);
            chk("irq", 32'h0000_0000, 32'(irq));
            rdchk("flags", OFF_FLAG, 32'h0000_0000);
        end
        // Suspend comes only from the idle timer; bit 1 is unused
        pulse(BIT_SUSPEND);
        rdchk("flags", OFF_FLAG, 32'h0000_0000);
        pulse(1);
        rdchk("flags", OFF_FLAG, 32'h0000_0000);
        chk("irq", 32'h0000_0000, 32'(irq));
    endtask : t_flags

    task automatic t_masked();
        apb(1'b1, OFF_ENABLE_CLR, 32'h0000_0080);
        pulse(BIT_RAM_UFLOW);
        chk("irq", 32'h0000_0000, 32'(irq));
        rdchk("flags", OFF_FLAG, 32'h0000_0080);
        apb(1'b1, OFF_ENABLE_SET, 32'h0000_0080);
        tick(1);
        chk("irq", 32'h0000_0001, 32'(irq));
        pulse(BIT_SOF);
        apb(1'b1, OFF_FLAG, 32'h0000_0080);
        tick(1);
        // One flag still pending keeps the line up
        chk("irq", 32'h0000_0001, 32'(irq));
        apb(1'b1, OFF_ENABLE_CLR, 32'h0000_0004);
        tick(1);
        chk("irq", 32'h0000_0000, 32'(irq));
        apb(1'b1, OFF_FLAG, 32'h0000_0004);
        rdchk("flags", OFF_FLAG, 32'h0000_0000);
    endtask : t_masked

    task automatic t_unmapped();
        apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
        chk("slverr", 32'h0000_0001, 32'(err));
        rdchk("unmapped", 12'h0F0, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, 32'(err));
    endtask : t_unmapped

    // Suspend needs 3 ms of idle, far beyond the run budget, so the line stays busy
    initial begin
        clk        = 1'b0;
        sys_rst    = 1'b1;
        req        = '0;
        ev         = 16'h0000;
        line_idle  = 1'b0;
        mismatches = 0;
        checks     = 0;
        tick(20);
        sys_rst <= 1'b0;
        tick(1);
        t_reset();
        t_enables();
        t_flags();
        t_masked();
        t_unmapped();
        finish_test();
    end

    initial begin
        tick(20000);
        mismatches++;
        finish_test();
    end
endmodule : usb_device_irq_enable_logic_bench
